// ===== core/rwbr_regs.svh
// constants for the receive word bit-slip realigner
// assumes it is included by bare name from the package and design files
`ifndef RWBR_REGS_SVH
`define RWBR_REGS_SVH

// ****************************************************************
// word widths
// ****************************************************************
`define RWBR_WORD_MAX 10
`define RWBR_WORD_NARROW 8
`define RWBR_CNT_W 4
`define RWBR_LAST_WIDE 4'h9
`define RWBR_LAST_NARROW 4'h7
`define RWBR_CNT_RESET 4'h0

// ****************************************************************
// buffering
// ****************************************************************
`define RWBR_FIFO_DEPTH 16

`endif

// ===== core/rwbr_pkg.sv
// types shared by the realigner and its buffer
// assumes rwbr_regs.svh is on the include path
`include "rwbr_regs.svh"

package rwbr_pkg;

    typedef logic [`RWBR_WORD_MAX-1:0] rwbr_word_t;
    typedef logic [`RWBR_CNT_W-1:0] rwbr_cnt_t;
    typedef logic [2*`RWBR_WORD_MAX-1:0] rwbr_pair_t;

    // pipeline fill of realignment registers 2 and 3
    typedef enum logic [2:0] {
        RWBR_EMPTY = 3'b001,
        RWBR_HALF = 3'b010,
        RWBR_RUN = 3'b100
    } rwbr_fill_e;

endpackage : rwbr_pkg

// ===== core/rwbr_stream_if.sv
// valid/ready word stream between the realigner and its buffer
// assumes both ends run on the same clock
`timescale 1ns/100ps

interface rwbr_stream_if;
    import rwbr_pkg::*;

    rwbr_word_t data;
    logic valid;
    logic ready;

    modport src (output data, output valid, input ready);
    modport snk (input data, input valid, output ready);

endinterface : rwbr_stream_if

// ===== core/rwbr_fifo.sv
// flip-flop fifo, parameterised width and depth, valid/ready on both sides
// assumes depth is a power of two and one clock for both sides
`timescale 1ns/100ps
`include "rwbr_regs.svh"

module rwbr_fifo
    import rwbr_pkg::*;
#(
    parameter int WIDTH = `RWBR_WORD_MAX,
    parameter int DEPTH = `RWBR_FIFO_DEPTH
) (
    input wire logic clk,
    input wire logic rst_n,
    rwbr_stream_if.snk wr,
    rwbr_stream_if.src rd
);

    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wrPtr_q;
    logic [AW-1:0] rdPtr_q;
    logic [AW:0] count_q;
    logic doWrite;
    logic doRead;

    // ****************************************************************
    // handshakes
    // ****************************************************************
    assign wr.ready = (count_q != (AW+1)'(DEPTH));
    assign rd.valid = (count_q != '0);
    assign rd.data = mem[rdPtr_q];
    assign doWrite = wr.valid && wr.ready;
    assign doRead = rd.valid && rd.ready;

    // ****************************************************************
    // storage and pointers
    // ****************************************************************
    always_ff @(posedge clk) begin
        if (doWrite) begin
            mem[wrPtr_q] <= wr.data;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            wrPtr_q <= '0;
            rdPtr_q <= '0;
        end else begin
            if (doWrite) begin
                wrPtr_q <= wrPtr_q + 1'b1;
            end
            if (doRead) begin
                rdPtr_q <= rdPtr_q + 1'b1;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            count_q <= '0;
        end else if (doWrite && !doRead) begin
            count_q <= count_q + 1'b1;
        end else if (doRead && !doWrite) begin
            count_q <= count_q - 1'b1;
        end
    end

endmodule : rwbr_fifo

// ===== core/rwbr_realigner.sv
// receive word bit-slip realigner for one channel, top level
// assumes words come from the deserializer on clk, one channel per instance,
// and that wordTen is static while traffic runs
`timescale 1ns/100ps
`include "rwbr_regs.svh"

module rwbr_realigner
    import rwbr_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic wordTen,
    input wire logic slipReq,
    input wire rwbr_word_t inData,
    input wire logic inValid,
    output logic inReady,
    output rwbr_word_t outData,
    output logic outValid,
    input wire logic outReady,
    output rwbr_cnt_t slipCount
);

    // ****************************************************************
    // helpers
    // ****************************************************************
    function automatic rwbr_cnt_t lastIndex(input logic ten);
        lastIndex = ten ? `RWBR_LAST_WIDE : `RWBR_LAST_NARROW;
    endfunction : lastIndex

    // window of one word taken from the older word upward by cnt bits
    function automatic rwbr_word_t selectWindow(
        input rwbr_word_t newer,
        input rwbr_word_t older,
        input rwbr_cnt_t cnt,
        input logic ten
    );
        rwbr_pair_t pair;
        rwbr_pair_t shifted;
        pair = ten ? {newer, older}
                   : {4'h0, newer[`RWBR_WORD_NARROW-1:0], older[`RWBR_WORD_NARROW-1:0]};
        shifted = pair >> cnt;
        selectWindow = shifted[`RWBR_WORD_MAX-1:0];
        if (!ten) begin
            selectWindow[`RWBR_WORD_MAX-1:`RWBR_WORD_NARROW] = 2'h0;
        end
    endfunction : selectWindow

    // ****************************************************************
    // phase fifo in front of the realigner
    // ****************************************************************
    rwbr_stream_if inStream ();
    rwbr_stream_if midStream ();

    assign inStream.data = inData;
    assign inStream.valid = inValid;
    assign inReady = inStream.ready;

    // depth is larger than the phase slack needs so downstream stalls are absorbed
    rwbr_fifo #(
        .WIDTH(`RWBR_WORD_MAX),
        .DEPTH(`RWBR_FIFO_DEPTH)
    ) phaseFifo (
        .clk(clk),
        .rst_n(rst_n),
        .wr(inStream.snk),
        .rd(midStream.src)
    );

    // ****************************************************************
    // word width select
    // ****************************************************************
    logic tenMeta_q;
    logic tenSync_q;

    // the width strap may come from a pin; not reset so it settles while reset is held
    always_ff @(posedge clk) begin
        tenMeta_q <= wordTen;
        tenSync_q <= tenMeta_q;
    end

    // ****************************************************************
    // slip request synchroniser and edge detect
    // ****************************************************************
    logic slipMeta_q;
    logic slipSync_q;
    logic slipPrev_q;
    logic slipEdge;

    // two flops since the request may come straight from a pin
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            slipMeta_q <= 1'b0;
            slipSync_q <= 1'b0;
            slipPrev_q <= 1'b0;
        end else begin
            slipMeta_q <= slipReq;
            slipSync_q <= slipMeta_q;
            slipPrev_q <= slipSync_q;
        end
    end

    // a held level gives one slip only
    assign slipEdge = slipSync_q && !slipPrev_q;

    // ****************************************************************
    // slip counter
    // ****************************************************************
    rwbr_cnt_t cnt_q;
    logic wrap;

    assign wrap = slipEdge && (cnt_q == lastIndex(tenSync_q));

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            cnt_q <= `RWBR_CNT_RESET;
        end else if (wrap) begin
            cnt_q <= `RWBR_CNT_RESET;
        end else if (slipEdge) begin
            cnt_q <= cnt_q + 1'b1;
        end
    end

    assign slipCount = cnt_q;

    // ****************************************************************
    // realignment registers 2 and 3
    // ****************************************************************
    rwbr_word_t reg2_q;
    rwbr_word_t reg3_q;
    rwbr_fill_e fill_q;
    logic advance;
    logic bubble_q;
    logic emit;

    // stall the fifo when the output word has not been taken
    assign advance = midStream.valid && (!outValid || outReady);
    assign midStream.ready = (!outValid || outReady);

    // a word leaves only once both realignment registers hold data
    assign emit = advance && (fill_q == RWBR_RUN);

    always_ff @(posedge clk) begin
        if (advance) begin
            reg2_q <= midStream.data;
            reg3_q <= reg2_q;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            fill_q <= RWBR_EMPTY;
        end else if (advance) begin
            case (fill_q)
                RWBR_EMPTY: begin
                    fill_q <= RWBR_HALF;
                end
                RWBR_HALF: begin
                    fill_q <= RWBR_RUN;
                end
                RWBR_RUN: begin
                    fill_q <= RWBR_RUN;
                end
                default: begin
                    fill_q <= RWBR_EMPTY;
                end
            endcase
        end
    end

    // after a wrap the window would repeat one word, so that word is dropped
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            bubble_q <= 1'b0;
        end else if (wrap) begin
            bubble_q <= 1'b1;
        end else if (emit) begin
            bubble_q <= 1'b0;
        end
    end

    // ****************************************************************
    // output word
    // ****************************************************************
    // a word leaving in the wrap cycle still uses the old offset, so it stays valid
    // and only the next one is dropped; dropping both would slip by width plus one
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            outValid <= 1'b0;
        end else if (emit) begin
            outValid <= !bubble_q;
        end else if (outReady) begin
            outValid <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            outData <= '0;
        end else if (emit) begin
            outData <= selectWindow(reg2_q, reg3_q, cnt_q, tenSync_q);
        end
    end

endmodule : rwbr_realigner

// ===== tb/rwbr_realigner_chk.sv
// assertions on the realigner ports
// assumes the package is compiled first; bound to the top at the foot
`timescale 1ns/100ps
`include "rwbr_regs.svh"

module rwbr_realigner_chk
    import rwbr_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic wordTen,
    input wire logic slipReq,
    input wire logic inReady,
    input wire rwbr_word_t outData,
    input wire logic outValid,
    input wire logic outReady,
    input wire rwbr_cnt_t slipCount
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    rwbr_cnt_t lastCnt;
    assign lastCnt = wordTen ? `RWBR_LAST_WIDE : `RWBR_LAST_NARROW;
    // ********
    // checks
    // ********
    reset_vals_a: assert property (disable iff (1'b0)
        !rst_n |=> !outValid && slipCount == 4'h0 && inReady)
        else $error("reset values wrong");
    cnt_range_a: assert property (slipCount <= lastCnt)
        else $error("slip count out of range");
    slip_step_a: assert property ($rose(slipReq) |-> ##[1:4] $changed(slipCount))
        else $error("slip edge not counted");
    slip_wrap_a: assert property ($changed(slipCount) |->
        slipCount == (($past(slipCount) == lastCnt) ? 4'h0 : $past(slipCount) + 4'h1))
        else $error("slip count step wrong");
    held_high_a: assert property (slipReq [*6] |-> $stable(slipCount))
        else $error("held request slipped again");
    quiet_cnt_a: assert property (!slipReq [*6] |-> $stable(slipCount))
        else $error("count moved without request");
    out_hold_a: assert property (outValid && !outReady |=> outValid && $stable(outData))
        else $error("output dropped while stalled");
    narrow_zero_a: assert property (outValid && !wordTen |-> outData[9:8] == 2'b00)
        else $error("narrow word upper bits set");
    wrap_c: cover property ($changed(slipCount) && slipCount == 4'h0);
    stall_c: cover property (outValid && !outReady);
    full_c: cover property (!inReady);
endmodule : rwbr_realigner_chk

bind rwbr_realigner rwbr_realigner_chk u_chk (.clk(clk), .rst_n(rst_n), .wordTen(wordTen),
    .slipReq(slipReq), .inReady(inReady), .outData(outData), .outValid(outValid),
    .outReady(outReady), .slipCount(slipCount));

// ===== tb/rwbr_ctrl_model.sv
// fabric controller that slips the realigner until its output matches a pattern
// assumes words arrive on the realigner clock
`timescale 1ns/100ps

module rwbr_ctrl_model
    import rwbr_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic enable,
    input wire logic longPulse,
    input wire rwbr_word_t pattern,
    input wire rwbr_word_t data,
    input wire logic valid,
    output logic slipReq
);
    rwbr_word_t data_q;
    logic valid_q;
    logic req_q;
    logic [4:0] timer_q;
    // ********
    // decide
    // ********
    // waits out the slip latency before judging again, so one mismatch is one slip
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            data_q <= 10'h000;
            valid_q <= 1'b0;
            req_q <= 1'b0;
            slipReq <= 1'b0;
            timer_q <= 5'h00;
        end else begin
            data_q <= data;
            valid_q <= valid;
            slipReq <= req_q;
            req_q <= timer_q > (longPulse ? 5'h06 : 5'h0D);
            if (timer_q != 5'h00) begin
                timer_q <= timer_q - 5'h01;
            end else if (enable && valid_q && data_q !== pattern) begin
                timer_q <= 5'h10;
            end
        end
    end
endmodule : rwbr_ctrl_model

// ===== tb/rwbr_realigner_tb.sv
// self-checking bench for the realigner and its controller
// assumes design files and the controller model are compiled first
`timescale 1ns/100ps

module rwbr_realigner_tb
    import rwbr_pkg::*;
;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic wordTen = 1'b1;
    logic slipReq;
    rwbr_word_t inData = 10'h000;
    logic inValid = 1'b0;
    logic inReady;
    rwbr_word_t outData;
    logic outValid;
    logic outReady = 1'b0;
    rwbr_cnt_t slipCount;
    rwbr_word_t pat = 10'h000;
    logic feed = 1'b0;
    logic seqMode = 1'b0;
    logic ctrlOn = 1'b0;
    logic longPulse = 1'b0;
    int failures = 0;
    int comparisons = 0;
    int sent = 0;
    int outs = 0;
    rwbr_word_t got[$];

    rwbr_realigner u_dut (.clk(clk), .rst_n(rst_n), .wordTen(wordTen), .slipReq(slipReq),
        .inData(inData), .inValid(inValid), .inReady(inReady), .outData(outData),
        .outValid(outValid), .outReady(outReady), .slipCount(slipCount));
    rwbr_ctrl_model u_ctrl (.clk(clk), .rst_n(rst_n), .enable(ctrlOn), .longPulse(longPulse),
        .pattern(pat), .data(outData), .valid(outValid && outReady), .slipReq(slipReq));

    initial begin
        forever #2 clk = ~clk;
    end
    // ********
    // driver and collector
    // ********
    // data only moves on acceptance, so a refused word is held
    always @(posedge clk) begin
        if (inValid && inReady) begin
            sent <= sent + 1;
            inData <= seqMode ? inData + 10'h001 : inData;
        end
        inValid <= feed;
        if (outValid && outReady) begin
            got.push_back(outData);
            outs <= outs + 1;
        end
    end

    task automatic chk(string name, logic [9:0] exp, logic [9:0] seen);
        comparisons++;
        if (seen !== exp) begin
            failures++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk

    task automatic finish_test();
        if (failures == 0 && comparisons > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : finish_test

    task automatic do_reset(logic ten);
        @(posedge clk);
        rst_n <= 1'b0;
        wordTen <= ten;
        feed <= 1'b0;
        ctrlOn <= 1'b0;
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        #1;
        chk("outValid", 10'h000, outValid);
        chk("slipCount", 10'h000, slipCount);
        chk("inReady", 10'h001, inReady);
        got.delete();
        sent = 0;
        outs = 0;
    endtask : do_reset

    task automatic stream_check();
        do_reset(1'b1);
        @(posedge clk);
        inData <= 10'h100;
        seqMode <= 1'b1;
        feed <= 1'b1;
        repeat (40) @(posedge clk);
        #1;
        chk("inReady full", 10'h000, inReady);
        repeat (60) begin
            @(posedge clk);
            outReady <= ~outReady;
        end
        @(posedge clk);
        feed <= 1'b0;
        outReady <= 1'b1;
        repeat (40) @(posedge clk);
        chk("words held back", 10'h001, (sent - got.size()) inside {[0:2]});
        chk("enough words", 10'h001, got.size() >= 40);
        foreach (got[i]) chk("outData", 10'(10'h100 + i), got[i]);
        seqMode <= 1'b0;
    endtask : stream_check

    task automatic align(logic ten, int k, rwbr_word_t p, logic lng, int drops);
        int w;
        rwbr_word_t d;
        w = ten ? 10 : 8;
        d = ((p << k) | (p >> (w - k))) & ((10'h001 << w) - 10'h001);
        @(posedge clk);
        feed <= 1'b0;
        ctrlOn <= 1'b0;
        repeat (2) @(posedge clk);
        inData <= d;
        pat <= p;
        longPulse <= lng;
        feed <= 1'b1;
        outReady <= 1'b1;
        // mixed old and new words must not be judged
        repeat (10) @(posedge clk);
        ctrlOn <= 1'b1;
        got.delete();
        repeat (400) @(posedge clk);
        #1;
        chk("slipCount", 10'(k), slipCount);
        chk("aligned word", p, got[$]);
        // two words stay in the realignment registers, each wrap since reset drops one
        feed <= 1'b0;
        repeat (30) @(posedge clk);
        #1;
        chk("words held back", 10'(drops), 10'(sent - outs));
    endtask : align

    initial begin
        stream_check();
        do_reset(1'b0);
        align(1'b0, 7, 10'h0E5, 1'b1, 2);
        do_reset(1'b1);
        align(1'b1, 3, 10'h2C7, 1'b0, 2);
        align(1'b1, 1, 10'h2C7, 1'b0, 3);
        finish_test();
    end

    // the run needs about 1500 cycles
    initial begin
        #80000;
        failures++;
        finish_test();
    end
endmodule : rwbr_realigner_tb
